// File: src/ndr_pkg.sv
package ndr_pkg;
  // ***************************************
  // Settings, limits and characters
  // ***************************************
  localparam logic [15:0] SA_RST = 16'h0000;
  localparam logic [15:0] SA_OFF = 16'hFFFF;
  localparam logic [15:0] GRP_ALL = 16'hFFFF;
  localparam logic [63:0] LONG_BCAST = 64'h0000_0000_0000_FFFF;
  localparam logic [7:0] NT_RST = 8'h19;
  localparam logic [7:0] NT_MIN = 8'h01;
  localparam logic [7:0] NT_MAX = 8'hFC;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_SP = 8'h20;
  localparam logic [7:0] CHR_TOP = 8'h7E;
  localparam logic [7:0] CHR_NUL = 8'h00;
  localparam logic [7:0] CHR_0 = 8'h30;
  localparam logic [7:0] CHR_A10 = 8'h37;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam int LBL_MAX = 20;
  // ***************************************
  // Timing
  // ***************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam int NT_UNIT_MS = 100;
  localparam int HOLD_TRIM_MS = 250;
  localparam int HOLD_MAX_MS = 2200;
  // ***************************************
  // Carriers
  // ***************************************
  typedef logic [LBL_MAX-1:0][7:0] ndr_lbl_t;
  typedef struct packed {
    logic valid;
    logic is_reply;
    logic long_dst;
    logic [63:0] dst;
    logic [63:0] src;
    logic [15:0] short_src;
    logic [15:0] group;
    logic [7:0] chan;
    logic [7:0] wait_t;
    logic [4:0] lbl_len;
    ndr_lbl_t lbl;
    logic [7:0] rssi;
  } ndr_pkt_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic frame_end;
    logic status;
  } ndr_host_t;
endpackage : ndr_pkg

// File: src/ndr_top.sv
`timescale 1ns/1ps
// How it works
// - Short address all ones disables reception of short-addressed packets.
// - Packets to our 64-bit serial number are always accepted.
// - Short source address is 16 bits wide and resets to zero.
// - Discovery reaches same channel and group; optional label filters responders.
// - Request goes out globally; request and reply use 64-bit addressing.
// - Replies are collected only during the discovery wait time.
// - Text mode: each reply ends CR CR, completion adds one CR.
// - Binary mode: discovery ends with an empty frame holding OK status.
// - A responder waits a random delay of at most 2.2 s.
// - Text reply: address, serial high, serial low, strength, label, CRs.
// - Binary reply: 2, 4, 4, 1 bytes then null-terminated label.
// - Label takes printable characters only, never a leading space.
// - Label entry ends on CR or after twenty characters.
// - Self response option one adds our own entry to results.
// - Wait time takes 0x01 to 0xFC in 100 ms, default 0x19.
// - The request carries our wait time.
// - Responder hold-off bound is received wait time minus 250 ms.
// - Replies arriving after discovery ended are discarded.
// - Only matching group talks; all-ones group sends to every group.
module ndr_top #(
  parameter int MS_CYCLES = ndr_pkg::MS_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic mode_binary,
  input wire logic sa_wr,
  input wire logic [15:0] sa_wdata,
  input wire logic nt_wr,
  input wire logic [7:0] nt_wdata,
  input wire logic self_opt,
  input wire logic [15:0] group_id,
  input wire logic [7:0] chan,
  input wire logic [31:0] serial_high,
  input wire logic [31:0] serial_low,
  input wire logic lbl_wr,
  input wire logic [7:0] lbl_char,
  input wire logic discover_cmd,
  input wire logic [4:0] disc_filt_len,
  input wire ndr_pkg::ndr_lbl_t disc_filt,
  input wire ndr_pkg::ndr_pkt_t rx,
  input wire logic host_ready,
  output ndr_pkg::ndr_pkt_t tx,
  output ndr_pkg::ndr_host_t host_out,
  output logic [15:0] short_source_address,
  output logic [7:0] discover_wait_time,
  output logic nt_reject,
  output logic lbl_reject,
  output logic discovering
);
  import ndr_pkg::*;

  typedef enum {R_IDLE, R_HOLD} ndr_rst_t;
  typedef enum {S_IDLE, S_NUM, S_NCR, S_LBL, S_XCR, S_END} ndr_sst_t;

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'hA) ? CHR_0 + {4'h0, n} : CHR_A10 + {4'h0, n};
  endfunction : hex_chr

  function automatic logic [3:0] fld_units(input logic [1:0] f, input logic bin);
    case (f)
      2'd0: fld_units = bin ? 4'd2 : 4'd4;
      2'd1, 2'd2: fld_units = bin ? 4'd4 : 4'd8;
      default: fld_units = bin ? 4'd1 : 4'd2;
    endcase
  endfunction : fld_units

  // ***************************************
  // Settings
  // ***************************************
  logic [15:0] sa_r, sa_nxt;
  logic [7:0] nt_r, nt_nxt;
  logic nt_rej_r, nt_rej_nxt;
  ndr_lbl_t lbl_r, lbl_nxt, ed_r, ed_nxt;
  logic [4:0] llen_r, llen_nxt, elen_r, elen_nxt;
  logic ebad_r, ebad_nxt, lrej_r, lrej_nxt;

  always_comb begin
    logic fin;
    fin = 1'b0;
    sa_nxt = sa_r;
    nt_nxt = nt_r;
    nt_rej_nxt = nt_rej_r;
    lbl_nxt = lbl_r;
    llen_nxt = llen_r;
    ed_nxt = ed_r;
    elen_nxt = elen_r;
    ebad_nxt = ebad_r;
    lrej_nxt = lrej_r;
    if (sa_wr) begin
      sa_nxt = sa_wdata;
    end
    if (nt_wr) begin
      nt_rej_nxt = (nt_wdata < NT_MIN) || (nt_wdata > NT_MAX);
      if (!nt_rej_nxt) begin
        nt_nxt = nt_wdata;
      end
    end
    if (lbl_wr) begin
      if (lbl_char == CHR_CR) begin
        fin = 1'b1;
      end else begin
        if (lbl_char < CHR_SP || lbl_char > CHR_TOP || (elen_r == 5'd0 && lbl_char == CHR_SP)) begin
          ebad_nxt = 1'b1;
        end
        ed_nxt[elen_r] = lbl_char;
        elen_nxt = elen_r + 5'd1;
        fin = (elen_nxt == 5'(LBL_MAX));
      end
      if (fin) begin
        // Whole string is refused, old label survives
        lrej_nxt = ebad_nxt;
        if (!ebad_nxt) begin
          lbl_nxt = ed_nxt;
          llen_nxt = elen_nxt;
        end
        ed_nxt = '0;
        elen_nxt = 5'd0;
        ebad_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sa_r <= SA_RST;
      nt_r <= NT_RST;
      nt_rej_r <= 1'b0;
      lbl_r <= '0;
      llen_r <= 5'd0;
      ed_r <= '0;
      elen_r <= 5'd0;
      ebad_r <= 1'b0;
      lrej_r <= 1'b0;
    end else begin
      sa_r <= sa_nxt;
      nt_r <= nt_nxt;
      nt_rej_r <= nt_rej_nxt;
      lbl_r <= lbl_nxt;
      llen_r <= llen_nxt;
      ed_r <= ed_nxt;
      elen_r <= elen_nxt;
      ebad_r <= ebad_nxt;
      lrej_r <= lrej_nxt;
    end
  end

  // ***************************************
  // Packet filter and responder
  // ***************************************
  logic net_ok, addr_ok, lbl_ok, req_go, disc_go;
  ndr_rst_t rs_r, rs_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic [11:0] hold_r, hold_nxt;
  logic [15:0] rms_r, rms_nxt;
  logic [63:0] rsrc_r, rsrc_nxt;

  always_comb begin
    int bnd;
    logic [28:0] prod;
    bnd = 0;
    prod = '0;
    // group match, all-ones is a send-to-all
    net_ok = rx.valid && rx.chan == chan && (rx.group == group_id || rx.group == GRP_ALL);
    if (rx.long_dst) begin
      addr_ok = rx.dst == {serial_high, serial_low} || rx.dst == LONG_BCAST;
    end else begin
      addr_ok = sa_r != SA_OFF && rx.dst[15:0] == sa_r;
    end
    lbl_ok = rx.lbl_len == 5'd0 || rx.lbl_len == llen_r;
    for (int i = 0; i < LBL_MAX; i++) begin
      if (rx.lbl_len != 5'd0 && 5'(i) < rx.lbl_len && rx.lbl[i] != lbl_r[i]) begin
        lbl_ok = 1'b0;
      end
    end
    req_go = net_ok && addr_ok && !rx.is_reply && lbl_ok;
    lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    rs_nxt = rs_r;
    hold_nxt = hold_r;
    rms_nxt = rms_r;
    rsrc_nxt = rsrc_r;
    case (rs_r)
      R_IDLE: begin
        if (req_go) begin
          bnd = int'(rx.wait_t) * NT_UNIT_MS - HOLD_TRIM_MS;
          if (bnd < 0) begin
            bnd = 0;
          end
          if (bnd > HOLD_MAX_MS) begin
            bnd = HOLD_MAX_MS;
          end
          prod = {13'h0, lfsr_r ^ serial_low[15:0]} * {16'h0, 13'(bnd + 1)};
          hold_nxt = prod[27:16];
          rms_nxt = 16'd0;
          rsrc_nxt = rx.src;
          rs_nxt = R_HOLD;
        end
      end
      R_HOLD: begin
        // Requests seen while holding are ignored, one reply at a time
        if (hold_r == 12'd0) begin
          if (!disc_go) begin
            rs_nxt = R_IDLE;
          end
        end else if (rms_r == 16'(MS_CYCLES - 1)) begin
          rms_nxt = 16'd0;
          hold_nxt = hold_r - 12'd1;
        end else begin
          rms_nxt = rms_r + 16'd1;
        end
      end
      default: rs_nxt = R_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rs_r <= R_IDLE;
      lfsr_r <= LFSR_SEED;
      hold_r <= 12'd0;
      rms_r <= 16'd0;
      rsrc_r <= '0;
    end else begin
      rs_r <= rs_nxt;
      lfsr_r <= lfsr_nxt;
      hold_r <= hold_nxt;
      rms_r <= rms_nxt;
      rsrc_r <= rsrc_nxt;
    end
  end

  // ***************************************
  // Requester and host serializer
  // ***************************************
  ndr_pkt_t tx_r, tx_nxt;
  ndr_host_t ho_r, ho_nxt;
  ndr_sst_t ss_r, ss_nxt;
  logic don_r, don_nxt, endp_r, endp_nxt;
  logic [15:0] dms_r, dms_nxt;
  logic [14:0] rem_r, rem_nxt;
  logic [87:0] num_r, num_nxt;
  logic [1:0] fld_r, fld_nxt;
  logic [3:0] unit_r, unit_nxt;
  ndr_lbl_t elbl_r, elbl_nxt;
  logic [4:0] elen2_r, elen2_nxt, lidx_r, lidx_nxt;

  assign disc_go = discover_cmd && !don_r && !endp_r && ss_r == S_IDLE;

  always_comb begin
    logic adv, take;
    adv = !ho_r.valid || host_ready;
    take = 1'b0;
    tx_nxt = '0;
    ho_nxt = ho_r;
    if (host_ready) begin
      ho_nxt.valid = 1'b0;
    end
    ss_nxt = ss_r;
    don_nxt = don_r;
    endp_nxt = endp_r;
    dms_nxt = dms_r;
    rem_nxt = rem_r;
    num_nxt = num_r;
    fld_nxt = fld_r;
    unit_nxt = unit_r;
    elbl_nxt = elbl_r;
    elen2_nxt = elen2_r;
    lidx_nxt = lidx_r;
    if (disc_go) begin
      tx_nxt.valid = 1'b1;
      tx_nxt.long_dst = 1'b1;
      tx_nxt.dst = LONG_BCAST;
      tx_nxt.wait_t = nt_r;
      tx_nxt.lbl_len = disc_filt_len;
      tx_nxt.lbl = disc_filt;
      don_nxt = 1'b1;
      dms_nxt = 16'd0;
      rem_nxt = 15'(nt_r * NT_UNIT_MS);
      if (self_opt) begin
        take = 1'b1;
        num_nxt = {sa_r, serial_high, serial_low, 8'h00};
        elbl_nxt = lbl_r;
        elen2_nxt = llen_r;
      end
    end else if (rs_r == R_HOLD && hold_r == 12'd0) begin
      tx_nxt.valid = 1'b1;
      tx_nxt.is_reply = 1'b1;
      tx_nxt.long_dst = 1'b1;
      tx_nxt.dst = rsrc_r;
      tx_nxt.lbl_len = llen_r;
      tx_nxt.lbl = lbl_r;
    end
    if (tx_nxt.valid) begin
      tx_nxt.src = {serial_high, serial_low};
      tx_nxt.short_src = sa_r;
      tx_nxt.group = group_id;
      tx_nxt.chan = chan;
    end
    if (don_r) begin
      if (dms_r == 16'(MS_CYCLES - 1)) begin
        dms_nxt = 16'd0;
        rem_nxt = rem_r - 15'd1;
        if (rem_r == 15'd1) begin
          don_nxt = 1'b0;
          endp_nxt = 1'b1;
        end
      end else begin
        dms_nxt = dms_r + 16'd1;
      end
      // only while window is open; no room while busy
      if (net_ok && rx.is_reply && rx.long_dst && rx.dst == {serial_high, serial_low} && ss_r == S_IDLE) begin
        take = 1'b1;
        num_nxt = {rx.short_src, rx.src, rx.rssi};
        elbl_nxt = rx.lbl;
        elen2_nxt = rx.lbl_len;
      end
    end
    if (take) begin
      ss_nxt = S_NUM;
      fld_nxt = 2'd0;
      unit_nxt = fld_units(2'd0, mode_binary);
      lidx_nxt = 5'd0;
    end else if (adv) begin
      ho_nxt = '0;
      ho_nxt.valid = ss_r != S_IDLE;
      case (ss_r)
        S_IDLE: begin
          if (endp_r) begin
            ss_nxt = S_END;
          end
        end
        S_NUM: begin
          ho_nxt.data = mode_binary ? num_r[87:80] : hex_chr(num_r[87:84]);
          num_nxt = mode_binary ? {num_r[79:0], 8'h00} : {num_r[83:0], 4'h0};
          unit_nxt = unit_r - 4'd1;
          if (unit_r == 4'd1) begin
            if (!mode_binary) begin
              ss_nxt = S_NCR;
            end else if (fld_r == 2'd3) begin
              ss_nxt = S_LBL;
            end else begin
              fld_nxt = fld_r + 2'd1;
              unit_nxt = fld_units(fld_nxt, mode_binary);
            end
          end
        end
        S_NCR: begin
          ho_nxt.data = CHR_CR;
          ss_nxt = fld_r == 2'd3 ? S_LBL : S_NUM;
          fld_nxt = fld_r + 2'd1;
          unit_nxt = fld_units(fld_nxt, mode_binary);
        end
        S_LBL: begin
          if (lidx_r == elen2_r) begin
            ho_nxt.data = mode_binary ? CHR_NUL : CHR_CR;
            ho_nxt.frame_end = mode_binary;
            ss_nxt = mode_binary ? S_IDLE : S_XCR;
          end else begin
            ho_nxt.data = elbl_r[lidx_r];
            lidx_nxt = lidx_r + 5'd1;
          end
        end
        S_XCR: begin
          ho_nxt.data = CHR_CR;
          ss_nxt = S_IDLE;
        end
        S_END: begin
          ho_nxt.data = mode_binary ? ST_OK : CHR_CR;
          ho_nxt.frame_end = mode_binary;
          ho_nxt.status = mode_binary;
          endp_nxt = 1'b0;
          ss_nxt = S_IDLE;
        end
        default: ss_nxt = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_r <= '0;
      ho_r <= '0;
      ss_r <= S_IDLE;
      don_r <= 1'b0;
      endp_r <= 1'b0;
      dms_r <= 16'd0;
      rem_r <= 15'd0;
      num_r <= '0;
      fld_r <= 2'd0;
      unit_r <= 4'd0;
      elbl_r <= '0;
      elen2_r <= 5'd0;
      lidx_r <= 5'd0;
    end else begin
      tx_r <= tx_nxt;
      ho_r <= ho_nxt;
      ss_r <= ss_nxt;
      don_r <= don_nxt;
      endp_r <= endp_nxt;
      dms_r <= dms_nxt;
      rem_r <= rem_nxt;
      num_r <= num_nxt;
      fld_r <= fld_nxt;
      unit_r <= unit_nxt;
      elbl_r <= elbl_nxt;
      elen2_r <= elen2_nxt;
      lidx_r <= lidx_nxt;
    end
  end

  assign tx = tx_r;
  assign host_out = ho_r;
  assign short_source_address = sa_r;
  assign discover_wait_time = nt_r;
  assign nt_reject = nt_rej_r;
  assign lbl_reject = lrej_r;
  assign discovering = don_r;
endmodule : ndr_top

// File: dv/ndr_assertions.sv
`timescale 1ns/1ps
// *****************
// Port checker
// *****************
module ndr_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sa_wr,
  input wire logic [15:0] sa_wdata,
  input wire logic nt_wr,
  input wire logic [7:0] nt_wdata,
  input wire logic host_ready,
  input wire ndr_pkg::ndr_pkt_t tx,
  input wire ndr_pkg::ndr_host_t host_out,
  input wire logic [15:0] short_source_address,
  input wire logic [7:0] discover_wait_time,
  input wire logic nt_reject,
  input wire logic discovering
);
  import ndr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic nt_bad;
  assign nt_bad = nt_wdata < NT_MIN || nt_wdata > NT_MAX;
  AST_SA_WR: assert property (sa_wr |=> short_source_address == $past(sa_wdata))
    else $error("short address write lost");
  AST_NT_OK: assert property (nt_wr && !nt_bad |=> discover_wait_time == $past(nt_wdata) && !nt_reject)
    else $error("good wait time not taken");
  AST_NT_BAD: assert property (nt_wr && nt_bad |=> nt_reject && $stable(discover_wait_time))
    else $error("bad wait time not refused");
  AST_NT_RANGE: assert property (discover_wait_time inside {[NT_MIN:NT_MAX]})
    else $error("wait time out of range");
  AST_REQ_FMT: assert property (tx.valid && !tx.is_reply |-> tx.long_dst && tx.dst == LONG_BCAST)
    else $error("request not global long");
  AST_REQ_WAIT: assert property (tx.valid && !tx.is_reply |-> tx.wait_t == $past(discover_wait_time))
    else $error("request lacks wait time");
  AST_DISC_TX: assert property ($rose(discovering) |-> tx.valid && !tx.is_reply)
    else $error("window opened without request");
  AST_RPL_FMT: assert property (tx.valid && tx.is_reply |-> tx.long_dst && tx.short_src == $past(short_source_address))
    else $error("reply not long addressed");
  // A stalled host must see the same byte again
  AST_HOST_HOLD: assert property (host_out.valid && !host_ready |=> host_out.valid && $stable(host_out))
    else $error("host byte changed while stalled");
  cover property (tx.valid && !tx.is_reply);
  cover property (tx.valid && tx.is_reply);
  cover property (host_out.valid && host_ready && host_out.frame_end && host_out.status);
endmodule : ndr_chk

bind ndr_top ndr_chk i_chk (.mclk, .arst_n, .sa_wr, .sa_wdata, .nt_wr, .nt_wdata, .host_ready, .tx,
  .host_out, .short_source_address, .discover_wait_time, .nt_reject, .discovering);

// File: dv/ndr_host_mdl.sv
`timescale 1ns/1ps
// *****************
// Host controller
// *****************
module ndr_host_mdl (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic slow,
  input wire ndr_pkg::ndr_host_t host_out,
  output logic host_ready
);
  import ndr_pkg::*;
  logic [9:0] q[$];
  // When slow, random stalls can keep a byte standing for several cycles
  always @(negedge mclk) host_ready <= arst_n && (!slow || $urandom_range(1, 0) == 1);
  always @(posedge mclk) if (host_out.valid && host_ready) q.push_back({host_out.status, host_out.frame_end, host_out.data});
endmodule : ndr_host_mdl

// File: dv/tb_top.sv
`timescale 1ns/1ps
// *****************
// Bench
// *****************
module tb_top;
  import ndr_pkg::*;
  localparam int MSC = 4;
  localparam string LAB = "NODE_LABEL_TWENTY_20";
  logic mclk = 0, arst_n = 0, mode_binary = 0, sa_wr = 0, nt_wr = 0, self_opt = 0;
  logic lbl_wr = 0, discover_cmd = 0, slow = 0, host_ready, nt_reject, lbl_reject, discovering;
  logic [15:0] sa_wdata = 0, group_id = 16'h2A5C, short_source_address;
  logic [7:0] nt_wdata = 0, chan = 8'h0C, lbl_char = 0, discover_wait_time, prev;
  logic [31:0] serial_high = 32'h01234567, serial_low = 0;
  logic [4:0] disc_filt_len = 0;
  logic [79:0] idv;
  logic [7:0] ntv[5] = '{8'h00, 8'hFD, 8'hFC, 8'hFF, 8'h01};
  ndr_lbl_t disc_filt = '0, lab_p;
  ndr_pkt_t rx = '0, tx, p;
  ndr_host_t host_out;
  logic [9:0] e[$];
  int errors = 0, checks = 0, n, c0, cyc = 0;

  initial forever #12.5 mclk = ~mclk;
  // Counted on the rising edge so that falling-edge readers never race it
  always @(posedge mclk) cyc++;

  ndr_top #(.MS_CYCLES(MSC)) i_dut (.mclk, .arst_n, .mode_binary, .sa_wr, .sa_wdata, .nt_wr, .nt_wdata,
    .self_opt, .group_id, .chan, .serial_high, .serial_low, .lbl_wr, .lbl_char, .discover_cmd,
    .disc_filt_len, .disc_filt, .rx, .host_ready, .tx, .host_out, .short_source_address,
    .discover_wait_time, .nt_reject, .lbl_reject, .discovering);
  ndr_host_mdl i_host (.mclk, .arst_n, .slow, .host_out, .host_ready);

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_q(input logic [9:0] m);
    chk(i_host.q.size(), e.size());
    foreach (e[i]) chk(i_host.q[i] & m, e[i]);
  endtask : chk_q
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask : pulse
  task automatic wr_sa(input logic [15:0] v);
    sa_wdata = v;
    pulse(sa_wr);
    tick(1);
  endtask : wr_sa
  task automatic lbl(input string s);
    for (int i = 0; i < s.len(); i++) begin
      lbl_char = s[i];
      lbl_wr = 1;
      tick(1);
    end
    lbl_wr = 0;
    tick(2);
  endtask : lbl
  // Released receive lines show the inverse, never the old packet
  task automatic send(input ndr_pkt_t q);
    rx = q;
    rx.valid = 1;
    tick(1);
    rx = ~q;
    rx.valid = 0;
  endtask : send
  task automatic wait_tx(input int lim);
    n = 0;
    while (!tx.valid && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_tx
  function automatic void hx(input logic [31:0] v, input int d);
    for (int i = d - 1; i >= 0; i--) e.push_back({2'b00, v[i*4+:4] < 10 ? CHR_0 + v[i*4+:4] : CHR_A10 + v[i*4+:4]});
    e.push_back({2'b00, CHR_CR});
  endfunction : hx
  task automatic req(input logic lg, input logic [63:0] dst, input logic [7:0] wt, input int fl,
      input logic [15:0] gx, input logic ok);
    int b;
    p = '0;
    {p.long_dst, p.dst, p.wait_t, p.lbl_len, p.lbl} = {lg, dst, wt, 5'(fl), lab_p};
    {p.src, p.chan, p.group} = {$urandom, $urandom, chan, group_id ^ gx};
    b = int'(wt) * 100 - 250;
    b = ok ? (b < 0 ? 0 : b > 2200 ? 2200 : b) * MSC + MSC + 8 : 60;
    send(p);
    wait_tx(b);
    chk(tx.valid, ok);
    if (ok) begin
      chk({tx.is_reply, tx.long_dst, tx.dst}, {2'b11, p.src});
      chk(n <= b, 1);
    end
  endtask : req
  task automatic dstart(input logic bin, input logic so);
    {mode_binary, self_opt} = {bin, so};
    i_host.q.delete();
    e.delete();
    pulse(discover_cmd);
    wait_tx(8);
    c0 = cyc;
    chk({tx.valid, tx.is_reply, tx.long_dst, tx.dst}, {3'b101, LONG_BCAST});
    chk({tx.wait_t, tx.lbl_len, tx.lbl}, {prev, disc_filt_len, disc_filt});
  endtask : dstart
  task automatic dend();
    while (discovering && cyc - c0 < 2000) tick(1);
    chk(cyc - c0, int'(prev) * 100 * MSC);
  endtask : dend

  initial begin
    void'($urandom(32'hF7F8DD60));
    serial_low = $urandom;
    for (int i = 0; i < LBL_MAX; i++) lab_p[i] = LAB[i];
    tick(20);
    arst_n = 1;
    tick(1);
    chk({short_source_address, discover_wait_time, nt_reject, lbl_reject, discovering, host_out.valid, tx.valid},
      {16'h0000, 8'h19, 5'b00000});
    prev = 8'h19;
    foreach (ntv[i]) begin
      nt_wdata = ntv[i];
      pulse(nt_wr);
      tick(1);
      if (ntv[i] inside {[8'h01:8'hFC]}) prev = ntv[i];
      chk({discover_wait_time, nt_reject}, {prev, !(ntv[i] inside {[8'h01:8'hFC]})});
    end
    lbl(" AB\015");
    chk(lbl_reject, 1);
    lbl("A\007\015");
    chk(lbl_reject, 1);
    lbl(LAB);
    chk(lbl_reject, 0);
    wr_sa(16'($urandom));
    chk(short_source_address, sa_wdata);
    // Binary run, own entry only, host stalling at random
    slow = 1;
    dstart(1, 1);
    dend();
    tick(150);
    idv = {sa_wdata, serial_high, serial_low};
    chk(i_host.q.size(), 33);
    for (int i = 0; i < 10; i++) chk(i_host.q[i][7:0], idv[79-8*i-:8]);
    chk({i_host.q[30][7:0], i_host.q[31][8], i_host.q[32]}, {LAB[19], 1'b1, 10'h300});
    // Text run with filter, one peer reply, a stray and a late one
    {slow, disc_filt_len, disc_filt} = {1'b0, 5'd20, lab_p};
    dstart(0, 0);
    tick(20);
    p = '0;
    {p.is_reply, p.long_dst, p.dst, p.src, p.short_src} = {2'b11, serial_high, serial_low, $urandom, $urandom, 16'($urandom)};
    {p.group, p.chan, p.rssi, p.lbl_len} = {group_id, chan, 8'($urandom), 5'd4};
    // Byte 0 is the last character
    p.lbl[3:0] = "REEP";
    send(p);
    hx(p.short_src, 4);
    hx(p.src[63:32], 8);
    hx(p.src[31:0], 8);
    hx(p.rssi, 2);
    for (int i = 0; i < 4; i++) e.push_back({2'b00, p.lbl[i]});
    repeat (3) e.push_back({2'b00, CHR_CR});
    tick(150);
    p.chan = ~chan;
    send(p);
    dend();
    p.chan = chan;
    send(p);
    tick(150);
    chk_q(10'h3FF);
    wr_sa(16'hFFFF);
    req(0, 64'hFFFF, 1, 0, 0, 0);
    req(1, {serial_high, serial_low}, 2, 0, 0, 1);
    wr_sa(16'h1234);
    req(0, 64'h1234, 1, 0, 0, 1);
    req(1, LONG_BCAST, 3, 1, 0, 0);
    req(1, LONG_BCAST, 4, 20, 0, 1);
    req(1, LONG_BCAST, 1, 0, 16'h0001, 0);
    req(1, LONG_BCAST, 1, 0, ~group_id, 1);
    req(1, LONG_BCAST, 8'h19, 0, 0, 1);
    repeat (4) req(1, LONG_BCAST, 8'($urandom_range(6, 1)), 0, 0, 1);
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
endmodule : tb_top
